/* File: hdl/pod_flt_accept.sv */
`timescale 1ns/1ps
// one fault input: falling edge or 16 consecutive low samples
module pod_flt_accept
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // carrier
    pod_flt_if.acceptor flt
);
    logic       last_reg;    // previous synced level for edge detect
    logic [7:0] div_reg;     // sample interval counter
    logic [4:0] low_reg;     // consecutive low samples seen
    logic       done_reg;    // level request already given, wait for high
    logic [7:0] div_lim;     // interval for current mode
    logic       tick;        // sample strobe

    // interval lookup
    always_comb
    begin
        unique case (pod_pkg::pod_mode_t'(flt.mode))
            pod_pkg::POD_MODE_S4:   div_lim = pod_pkg::POD_DIV_4;
            pod_pkg::POD_MODE_S16:  div_lim = pod_pkg::POD_DIV_16;
            pod_pkg::POD_MODE_S128: div_lim = pod_pkg::POD_DIV_128;
            pod_pkg::POD_MODE_EDGE: div_lim = pod_pkg::POD_DIV_4;
        endcase
    end

    assign tick = (div_reg == div_lim - 8'h01);

    // edge history
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            last_reg <= 1'b1;
        else
            last_reg <= flt.pin_sync;
    end

    // sample interval counter
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || tick)
            div_reg <= 8'h00;
        else
            div_reg <= div_reg + 8'h01;
    end

    // low sample run counter; a high sample restarts the run
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            low_reg  <= 5'h00;
            done_reg <= 1'b0;
        end
        else if (flt.pin_sync)
        begin
            low_reg  <= 5'h00;
            done_reg <= 1'b0;
        end
        else if (tick && !done_reg)
        begin
            if (low_reg == pod_pkg::POD_LOW_COUNT - 5'h01)
            begin
                low_reg  <= 5'h00;
                done_reg <= 1'b1;   // one request per low period
            end
            else
                low_reg <= low_reg + 5'h01;
        end
    end

    // request pulse, combinational; the top registers it
    always_comb
    begin
        if (flt.mode == pod_pkg::POD_MODE_EDGE)
            flt.accept = last_reg && !flt.pin_sync;
        else
            flt.accept = !flt.pin_sync && tick && !done_reg
                         && (low_reg == pod_pkg::POD_LOW_COUNT - 5'h01);
    end
endmodule

/* File: hdl/pod_flt_if.sv */
`timescale 1ns/1ps
// carrier between top and one fault input acceptor
interface pod_flt_if;
    logic       pin_sync;   // synchronised pin level
    logic [1:0] mode;       // acceptance mode
    logic       accept;     // one-cycle request pulse
    modport acceptor (input pin_sync, input mode, output accept);
    modport owner    (output pin_sync, output mode, input accept);
endinterface

/* File: hdl/pod_pkg.sv */
package pod_pkg;
    // input acceptance modes
    typedef enum logic [1:0]
    {
        POD_MODE_EDGE = 2'h0,
        POD_MODE_S4   = 2'h1,
        POD_MODE_S16  = 2'h2,
        POD_MODE_S128 = 2'h3
    } pod_mode_t;

    // sample intervals in peripheral clock cycles
    localparam logic [7:0] POD_DIV_4   = 8'h04;
    localparam logic [7:0] POD_DIV_16  = 8'h10;
    localparam logic [7:0] POD_DIV_128 = 8'h80;
    // consecutive low samples needed for a level request
    localparam logic [4:0] POD_LOW_COUNT = 5'h10;

    // reset values of configuration
    localparam logic [1:0] POD_SHORT_HIZ_RST   = 2'h0;
    localparam logic [1:0] POD_SHORT_IRQ_RST   = 2'h3;
    localparam logic [3:0] POD_SINGLE_EN_RST   = 4'h0;
    localparam logic [2:0] POD_GRP_A_EN_RST    = 3'h7;
    localparam logic [2:0] POD_GRP_B_EN_RST    = 3'h7;
    localparam logic       POD_AUX_EN_RST      = 1'b1;
    localparam logic [3:0] POD_EXT_RST         = 4'h0;
    localparam logic [3:0] POD_SOFT_RST        = 4'h0;
    localparam logic [5:0] POD_ALV_A_RST       = 6'h00;

    // extended-condition masks: input n may be added to the group
    localparam logic [3:0] POD_EXT_OK_A      = 4'hE;
    localparam logic [3:0] POD_EXT_OK_B      = 4'hD;
    localparam logic [3:0] POD_EXT_OK_SINGLE = 4'hB;
    localparam logic [3:0] POD_EXT_OK_AUX    = 4'hF;
endpackage

/* File: hdl/pod_unit.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - group A shorts on six complementary pairs
// - group B shorts on three complementary pairs
// - separate short settings per bridge group
// - short hiz enable gates pin disable
// - short interrupt enable gates request
// - reset: short hiz off, irq on
// - single-timer pins float on their causes
// - group A subgroups float on their causes
// - group B subgroups float on their causes
// - aux pair floats on its causes
// - causes ORed, gated by subgroup enable
// - reset enables: single off, others on
// - allowed extended inputs per group
// - several extended inputs may combine
// - extended bits add inputs, reset clear
// - one oscillator-fault enable for all
// - accept on edge or sixteen low samples
// - selectable active level per group A pair
// - configuration writable once until reset
// - software request bit per group
module pod_unit
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // fault pins, active low, asynchronous
    input  wire logic [3:0]  fault_in_n,
    // oscillator stop / clock monitor error, asynchronous level
    input  wire logic        osc_stop,
    input  wire logic        clock_monitor_error,
    // timer output levels: group A pairs {a,b} x6, group B pairs x3
    input  wire logic [11:0] grp_a_out,
    input  wire logic [5:0]  grp_b_out,
    // configuration, taken by cfg_commit once
    input  wire logic        cfg_commit,
    input  wire logic [7:0]  cfg_mode,
    input  wire logic        cfg_osc_en,
    input  wire logic [5:0]  cfg_alv_a,
    input  wire logic [1:0]  cfg_short_hiz,
    input  wire logic [1:0]  cfg_short_irq,
    input  wire logic [3:0]  cfg_fault_irq,
    input  wire logic [3:0]  cfg_single_en,
    input  wire logic [2:0]  cfg_grp_a_en,
    input  wire logic [2:0]  cfg_grp_b_en,
    input  wire logic        cfg_aux_en,
    input  wire logic [3:0]  cfg_ext_a,
    input  wire logic [3:0]  cfg_ext_b,
    input  wire logic [3:0]  cfg_ext_single,
    input  wire logic [3:0]  cfg_ext_aux,
    // software requests {aux, single, b, a}, live
    input  wire logic [3:0]  soft_req,
    // flag clears, one-cycle pulses
    input  wire logic [3:0]  fault_clr,
    input  wire logic [1:0]  short_clr,
    input  wire logic        osc_clr,
    // status
    output logic             cfg_locked,
    output logic [3:0]       fault_flag,
    output logic [1:0]       short_flag,
    output logic             osc_flag,
    // pin disables, high means pins floated
    output logic [3:0]       single_hiz,
    output logic [2:0]       grp_a_hiz,
    output logic [2:0]       grp_b_hiz,
    output logic             aux_hiz,
    // interrupt lines, one per fault input
    output logic [3:0]       irq
);
    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    // every foreign input takes two flops
    // timer outputs too: other clock domain
    // cost: two cycles on every cause but soft requests
    logic [3:0]  flt_s1_reg;    // first stage, read only by second
    logic [3:0]  flt_s2_reg;
    logic [1:0]  osc_s1_reg;
    logic [1:0]  osc_s2_reg;
    logic [11:0] a_s1_reg;
    logic [11:0] a_s2_reg;
    logic [5:0]  b_s1_reg;
    logic [5:0]  b_s2_reg;

    // two flops per asynchronous input
    // reset to idle levels: no false event
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            flt_s1_reg <= 4'hF;
            flt_s2_reg <= 4'hF;
            osc_s1_reg <= 2'h0;
            osc_s2_reg <= 2'h0;
            // ones: inactive at reset level (low)
            // so no false short right after reset
            a_s1_reg   <= 12'hFFF;
            a_s2_reg   <= 12'hFFF;
            b_s1_reg   <= 6'h3F;
            b_s2_reg   <= 6'h3F;
        end
        else
        begin
            flt_s1_reg <= fault_in_n;
            flt_s2_reg <= flt_s1_reg;
            osc_s1_reg <= {clock_monitor_error, osc_stop};
            osc_s2_reg <= osc_s1_reg;
            a_s1_reg   <= grp_a_out;
            a_s2_reg   <= a_s1_reg;
            b_s1_reg   <= grp_b_out;
            b_s2_reg   <= b_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-time configuration
    // all taken on the first commit only
    // later strobes dropped: a stray write
    // cannot loosen the protection
    logic        lock_reg;
    logic [7:0]  mode_reg;
    logic        osc_en_reg;
    logic [5:0]  alv_a_reg;       // 1 = active high, per pair
    logic [1:0]  short_hiz_reg;   // {b, a}
    logic [1:0]  short_irq_reg;
    logic [3:0]  fault_irq_reg;
    logic [3:0]  single_en_reg;
    logic [2:0]  grp_a_en_reg;
    logic [2:0]  grp_b_en_reg;
    logic        aux_en_reg;
    logic [3:0]  ext_a_reg;
    logic [3:0]  ext_b_reg;
    logic [3:0]  ext_single_reg;
    logic [3:0]  ext_aux_reg;

    // settings latch once; later commits ignored until reset
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            lock_reg       <= 1'b0;
            mode_reg       <= 8'h00;
            osc_en_reg     <= 1'b0;
            alv_a_reg      <= pod_pkg::POD_ALV_A_RST;
            short_hiz_reg  <= pod_pkg::POD_SHORT_HIZ_RST;
            short_irq_reg  <= pod_pkg::POD_SHORT_IRQ_RST;
            fault_irq_reg  <= 4'h0;
            single_en_reg  <= pod_pkg::POD_SINGLE_EN_RST;
            grp_a_en_reg   <= pod_pkg::POD_GRP_A_EN_RST;
            grp_b_en_reg   <= pod_pkg::POD_GRP_B_EN_RST;
            aux_en_reg     <= pod_pkg::POD_AUX_EN_RST;
            ext_a_reg      <= pod_pkg::POD_EXT_RST;
            ext_b_reg      <= pod_pkg::POD_EXT_RST;
            ext_single_reg <= pod_pkg::POD_EXT_RST;
            ext_aux_reg    <= pod_pkg::POD_EXT_RST;
        end
        else if (cfg_commit && !lock_reg)
        begin
            lock_reg       <= 1'b1;
            mode_reg       <= cfg_mode;
            osc_en_reg     <= cfg_osc_en;
            alv_a_reg      <= cfg_alv_a;
            short_hiz_reg  <= cfg_short_hiz;
            short_irq_reg  <= cfg_short_irq;
            fault_irq_reg  <= cfg_fault_irq;
            single_en_reg  <= cfg_single_en;
            grp_a_en_reg   <= cfg_grp_a_en;
            grp_b_en_reg   <= cfg_grp_b_en;
            aux_en_reg     <= cfg_aux_en;
            // disallowed inputs are masked off
            ext_a_reg      <= cfg_ext_a & pod_pkg::POD_EXT_OK_A;
            ext_b_reg      <= cfg_ext_b & pod_pkg::POD_EXT_OK_B;
            ext_single_reg <= cfg_ext_single & pod_pkg::POD_EXT_OK_SINGLE;
            ext_aux_reg    <= cfg_ext_aux & pod_pkg::POD_EXT_OK_AUX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fault input acceptors
    // one acceptor per pin, one-cycle pulse
    // the sticky flags below catch it
    logic [3:0] accept;   // one-cycle request pulses

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_flt
            pod_flt_if flt ();
            assign flt.pin_sync = flt_s2_reg[gi];
            // two mode bits per input
            assign flt.mode     = mode_reg[2*gi +: 2];
            assign accept[gi]   = flt.accept;
            pod_flt_accept pod_flt_accept_inst
            (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .flt     (flt)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // short-circuit detection
    // short: both halves at the active level
    // group B has no levels of its own

    // both halves of a pair at their active level
    // hi set: both must read one
    function automatic logic pair_short(input logic [1:0] lv, input logic hi);
        pair_short = hi ? (lv[0] & lv[1]) : (~lv[0] & ~lv[1]);
    endfunction

    logic short_a;   // any group A pair shorted
    logic short_b;   // any group B pair shorted

    // group B shares group A timer3 active levels
    // unrolled OR tree, no priority
    always_comb
    begin
        short_a = 1'b0;
        for (int i = 0; i < 6; i++)
            short_a = short_a | pair_short(a_s2_reg[2*i +: 2], alv_a_reg[i]);
        short_b = 1'b0;
        for (int i = 0; i < 3; i++)
            short_b = short_b | pair_short(b_s2_reg[2*i +: 2], alv_a_reg[i]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags; set wins over clear
    // a clear meeting a live cause is lost:
    // the fault is still there, pins stay off
    logic [3:0] fault_reg;
    logic [1:0] short_reg;
    logic       osc_reg;

    // fault request flags
    // acceptor pulses set, strobes clear
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            fault_reg <= 4'h0;
        else
            fault_reg <= accept | (fault_reg & ~fault_clr);
    end

    // short flags, set whether or not short hiz/irq used
    // kept even with hiz and irq disabled
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            short_reg <= 2'h0;
        else
            short_reg <= {short_b, short_a} | (short_reg & ~short_clr);
    end

    // oscillator fault flag, gated by the oscillator-fault enable
    // enable off: never sets, nothing floats
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            osc_reg <= 1'b0;
        else
            osc_reg <= (osc_en_reg & (|osc_s2_reg)) | (osc_reg & ~osc_clr);
    end

    ////////////////////////////////////////////////////////////////////////////
    // disable causes per group
    // own input, soft request, oscillator
    // and the masked extended inputs
    // soft requests are live, not latched
    logic cause_a;
    logic cause_b;
    logic cause_s;
    logic cause_x;

    // causes ORed; extended inputs each add independently
    // masks applied at commit, not here
    always_comb
    begin
        cause_a = (short_reg[0] & short_hiz_reg[0]) | fault_reg[0] | soft_req[0]
                  | osc_reg | (|(ext_a_reg & fault_reg));
        cause_b = (short_reg[1] & short_hiz_reg[1]) | fault_reg[1] | soft_req[1]
                  | osc_reg | (|(ext_b_reg & fault_reg));
        cause_s = fault_reg[2] | soft_req[2] | osc_reg
                  | (|(ext_single_reg & fault_reg));
        cause_x = fault_reg[3] | soft_req[3] | osc_reg
                  | (|(ext_aux_reg & fault_reg));
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    // subgroup enable is the last gate
    // flops keep the pins glitch free
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            single_hiz <= 4'h0;
            grp_a_hiz  <= 3'h0;
            grp_b_hiz  <= 3'h0;
            aux_hiz    <= 1'b0;
        end
        else
        begin
            single_hiz <= single_en_reg & {4{cause_s}};
            grp_a_hiz  <= grp_a_en_reg & {3{cause_a}};
            grp_b_hiz  <= grp_b_en_reg & {3{cause_b}};
            aux_hiz    <= aux_en_reg & cause_x;
        end
    end

    // interrupt lines; shorts share lines 0 and 1
    // levels; drop one cycle after a clear
    // shorts use line 0 (A) and 1 (B)
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
            irq <= 4'h0;
        else
            irq <= (fault_reg & fault_irq_reg)
                   | {2'h0, short_reg & short_irq_reg};
    end

    // status mirrors
    // lag the internal flags by a cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rstn)
        begin
            cfg_locked <= 1'b0;
            fault_flag <= 4'h0;
            short_flag <= 2'h0;
            osc_flag   <= 1'b0;
        end
        else
        begin
            cfg_locked <= lock_reg;
            fault_flag <= fault_reg;
            short_flag <= short_reg;
            osc_flag   <= osc_reg;
        end
    end
endmodule

/* File: verif/pod_far_end.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// timer output stages and fault pins facing the unit
module pod_far_end
(
    // clock
    input  wire logic  clk_sys,
    // fault pins, pulled up when nobody pulls low
    output logic [3:0]  fault_in_n,
    // complementary timer outputs
    output logic [11:0] grp_a_out,
    output logic [5:0]  grp_b_out
);
    // idle: pins high; pairs 0 and 3 split so neither level reads as short
    initial
    begin
        fault_in_n = 4'hF;
        grp_a_out = 12'hF7D;
        grp_b_out = 6'h3F;
    end
    // every change lands just after an edge
    task automatic pin(input int n, input logic lvl);
        @(posedge clk_sys);
        #1;
        fault_in_n[n] = lvl;
    endtask
    task automatic pair_a(input int i, input logic [1:0] v);
        @(posedge clk_sys);
        #1;
        grp_a_out[2*i +: 2] = v;
    endtask
    task automatic pair_b(input int i, input logic [1:0] v);
        @(posedge clk_sys);
        #1;
        grp_b_out[2*i +: 2] = v;
    endtask
endmodule

/* File: verif/pod_unit_monitor.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level checker for the output disable unit
module pod_unit_monitor
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // inputs that cause events
    input  wire logic [11:0] grp_a_out,
    input  wire logic [5:0]  grp_b_out,
    input  wire logic [3:0]  soft_req,
    input  wire logic [3:0]  fault_clr,
    // status and pin disables
    input  wire logic        cfg_locked,
    input  wire logic [3:0]  fault_flag,
    input  wire logic [1:0]  short_flag,
    input  wire logic [3:0]  single_hiz,
    input  wire logic [2:0]  grp_a_hiz,
    input  wire logic [2:0]  grp_b_hiz,
    input  wire logic        aux_hiz,
    input  wire logic [3:0]  irq
);
    default clocking dcb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////
    // both outputs of a pair at the reset active level (low)
    sequence pair_a5_short;
        !cfg_locked && grp_a_out[11:10] == 2'h0;
    endsequence
    sequence pair_b0_short;
        !cfg_locked && grp_b_out[1:0] == 2'h0;
    endsequence
    // first cycle that fault input 0 shows as flagged
    sequence fault0_rise;
        !cfg_locked && $rose(fault_flag[0]);
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // reset must leave every disable and request quiet
    reset_quiet_a: assert property (disable iff (1'b0) !rstn |=>
        {cfg_locked, single_hiz, grp_a_hiz, grp_b_hiz, aux_hiz, irq} == 16'h0000)
        else $error("outputs not quiet after reset");
    soft_a_float_a: assert property (!cfg_locked && soft_req[0] |=> grp_a_hiz == 3'h7)
        else $error("group a ignores soft request");
    single_off_a: assert property (!cfg_locked |-> single_hiz == 4'h0)
        else $error("single pins float while disabled");
    lock_sticky_a: assert property (cfg_locked |=> cfg_locked)
        else $error("lock dropped");
    flag_hold_a: assert property (fault_flag[1] && !fault_clr[1] &&
        !$past(fault_clr[1]) |=> fault_flag[1]) else $error("fault flag lost");
    fault_float_a: assert property (fault0_rise |-> grp_a_hiz == 3'h7)
        else $error("fault 0 does not float group a");
    short_irq_a: assert property (!cfg_locked && short_flag[1] |-> irq[1])
        else $error("short without request");
    short_a_seen_a: assert property (pair_a5_short |-> ##[2:4] short_flag[0])
        else $error("group a short missed");
    short_b_seen_a: assert property (pair_b0_short |-> ##[2:4] short_flag[1])
        else $error("group b short missed");
    short_nohiz_a: assert property (!cfg_locked && short_flag[0] && fault_flag == 4'h0 &&
        $past(soft_req) == 4'h0 && $past(fault_flag) == 4'h0 |-> grp_a_hiz == 3'h0)
        else $error("short floats pins with hiz off");
endmodule

/* File: verif/pod_unit_test.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pod_unit_test;
    // drives
    logic        clk_sys, rstn, osc_stop, clock_monitor_error, cfg_commit, cfg_osc_en;
    logic        cfg_aux_en, osc_clr;
    logic [7:0]  cfg_mode;
    logic [5:0]  cfg_alv_a;
    logic [3:0]  cfg_fault_irq, cfg_single_en, cfg_ext_a, cfg_ext_b, cfg_ext_single;
    logic [3:0]  cfg_ext_aux, soft_req, fault_clr;
    logic [2:0]  cfg_grp_a_en, cfg_grp_b_en;
    logic [1:0]  cfg_short_hiz, cfg_short_irq, short_clr;
    // observed
    wire  [3:0]  fault_in_n, fault_flag, single_hiz, irq;
    wire  [11:0] grp_a_out;
    wire  [5:0]  grp_b_out;
    wire  [2:0]  grp_a_hiz, grp_b_hiz;
    wire  [1:0]  short_flag;
    wire         cfg_locked, osc_flag, aux_hiz;
    int          err_total, samples_checked;
    ////////////////////////////////////////////////////////////////////////////
    pod_unit pod_unit_inst
    (
        .clk_sys(clk_sys), .rstn(rstn), .fault_in_n(fault_in_n), .osc_stop(osc_stop),
        .clock_monitor_error(clock_monitor_error), .grp_a_out(grp_a_out),
        .grp_b_out(grp_b_out), .cfg_commit(cfg_commit), .cfg_mode(cfg_mode),
        .cfg_osc_en(cfg_osc_en), .cfg_alv_a(cfg_alv_a), .cfg_short_hiz(cfg_short_hiz),
        .cfg_short_irq(cfg_short_irq), .cfg_fault_irq(cfg_fault_irq),
        .cfg_single_en(cfg_single_en), .cfg_grp_a_en(cfg_grp_a_en),
        .cfg_grp_b_en(cfg_grp_b_en), .cfg_aux_en(cfg_aux_en), .cfg_ext_a(cfg_ext_a),
        .cfg_ext_b(cfg_ext_b), .cfg_ext_single(cfg_ext_single), .cfg_ext_aux(cfg_ext_aux),
        .soft_req(soft_req), .fault_clr(fault_clr), .short_clr(short_clr),
        .osc_clr(osc_clr), .cfg_locked(cfg_locked), .fault_flag(fault_flag),
        .short_flag(short_flag), .osc_flag(osc_flag), .single_hiz(single_hiz),
        .grp_a_hiz(grp_a_hiz), .grp_b_hiz(grp_b_hiz), .aux_hiz(aux_hiz), .irq(irq)
    );
    pod_far_end pod_far_end_inst
    (
        .clk_sys(clk_sys), .fault_in_n(fault_in_n), .grp_a_out(grp_a_out),
        .grp_b_out(grp_b_out)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // land just after an edge, away from the sampling instant
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // all pin disables: {single, a, b, aux}
    function automatic logic [11:0] hz();
        return {1'b0, single_hiz, grp_a_hiz, grp_b_hiz, aux_hiz};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // software request per group, reset enables in force
    task automatic t_soft();
        logic [11:0] exp [4] = '{12'h070, 12'h00E, 12'h000, 12'h001};
        for (int g = 0; g < 4; g++)
        begin
            soft_req = 4'h1 << g;
            step(2);
            chk("soft hiz", hz(), exp[g]);
            soft_req = 4'h0;
            step(2);
        end
    endtask
    // one falling fault pin; flag must outlive the pin until cleared
    task automatic t_fault(input int n, input int dly, input logic [11:0] eh, input logic [3:0] ei);
        pod_far_end_inst.pin(n, 1'b0);
        step(dly);
        chk("fault flag", fault_flag, 12'h1 << n);
        chk("fault hiz", hz(), eh);
        chk("fault irq", irq, ei);
        pod_far_end_inst.pin(n, 1'b1);
        step(3);
        chk("held flag", fault_flag, 12'h1 << n);
        chk("held hiz", hz(), eh);
        fault_clr[n] = 1'b1;
        step(1);
        fault_clr = 4'h0;
        step(4);
        chk("cleared hiz", hz(), 12'h000);
    endtask
    // short in each bridge group at reset levels: flag and request only
    task automatic t_short();
        for (int g = 0; g < 2; g++)
        begin
            if (g == 0)
                pod_far_end_inst.pair_a(5, 2'h0);
            else
                pod_far_end_inst.pair_b(0, 2'h0);
            step(6);
            chk("short flag", short_flag, 12'h1 << g);
            chk("short irq", irq, 12'h1 << g);
            chk("short hiz", hz(), 12'h000);
            if (g == 0)
                pod_far_end_inst.pair_a(5, 2'h3);
            else
                pod_far_end_inst.pair_b(0, 2'h3);
            step(3);
            short_clr = 2'h3;
            step(1);
            short_clr = 2'h0;
            step(4);
            chk("short gone", {short_flag, irq}, 12'h000);
        end
    endtask
    // oscillator cause, raised on the given line then cleared
    task automatic t_osc(input logic mon, input logic ef, input logic [11:0] eh);
        osc_stop = !mon;
        clock_monitor_error = mon;
        step(6);
        chk("osc flag", osc_flag, ef);
        chk("osc hiz", hz(), eh);
        osc_stop = 1'b0;
        clock_monitor_error = 1'b0;
        // let the synchroniser drain, else the set wins over the clear
        step(3);
        osc_clr = 1'b1;
        step(1);
        osc_clr = 1'b0;
        step(4);
        chk("osc gone", {osc_flag, hz()}, 20'h00000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial
    begin
        #2000000;
        err_total++;
        test_done();
    end
    initial
    begin
        {rstn, osc_stop, clock_monitor_error, cfg_commit, osc_clr} = 5'h00;
        {soft_req, fault_clr, short_clr} = 10'h000;
        cfg_mode = 8'hB4; // inputs: 0 edge, 1 every 4, 2 every 128, 3 every 16
        {cfg_osc_en, cfg_alv_a, cfg_short_hiz, cfg_short_irq} = 11'h487;
        {cfg_fault_irq, cfg_single_en, cfg_grp_a_en, cfg_grp_b_en, cfg_aux_en} = 15'h7FFB;
        {cfg_ext_a, cfg_ext_b, cfg_ext_single, cfg_ext_aux} = 16'h1085;
        step(3);
        rstn = 1'b1;
        step(1);
        chk("reset hiz", {short_flag, cfg_locked, hz()}, 12'h000);
        t_soft();
        t_fault(0, 6, 12'h070, 4'h0);
        t_fault(1, 6, 12'h00E, 4'h0);
        t_fault(2, 6, 12'h000, 4'h0);
        t_fault(3, 6, 12'h001, 4'h0);
        t_short();
        t_osc(1'b0, 1'b0, 12'h000);
        cfg_commit = 1'b1;
        step(1);
        cfg_commit = 1'b0;
        cfg_single_en = 4'h0;
        step(2);
        chk("locked", cfg_locked, 12'h1);
        cfg_commit = 1'b1;
        step(1);
        cfg_commit = 1'b0;
        t_osc(1'b1, 1'b1, 12'h7FB);
        t_fault(0, 6, 12'h071, 4'h1);
        t_fault(3, 300, 12'h781, 4'h8);
        t_fault(2, 2100, 12'h781, 4'h4);
        pod_far_end_inst.pin(1, 1'b0);
        step(20);
        chk("level early", fault_flag, 12'h000);
        t_fault(1, 60, 12'h00A, 4'h2);
        pod_far_end_inst.pair_a(3, 2'h3);
        step(6);
        chk("active high short", {short_flag, irq, hz()}, 20'h11070);
        test_done();
    end
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pod_unit pod_unit_monitor pod_unit_monitor_inst
(
    .clk_sys(clk_sys), .rstn(rstn), .grp_a_out(grp_a_out), .grp_b_out(grp_b_out),
    .soft_req(soft_req), .fault_clr(fault_clr), .cfg_locked(cfg_locked),
    .fault_flag(fault_flag), .short_flag(short_flag), .single_hiz(single_hiz),
    .grp_a_hiz(grp_a_hiz), .grp_b_hiz(grp_b_hiz), .aux_hiz(aux_hiz), .irq(irq)
);
